// *** common/spp_regs_map.vh ***
// register offsets, field positions and reset values of the port policy bank
// assumes an 8-bit register access port with 8-bit addresses
`ifndef SPP_REGS_MAP_VH
`define SPP_REGS_MAP_VH

`define SPP_OFS_P1_MIRROR_VLAN   8'h11
`define SPP_OFS_P1_FILTER_FLOW   8'h12
`define SPP_OFS_P1_TAG_HIGH      8'h13
`define SPP_OFS_P1_TAG_LOW       8'h14
`define SPP_OFS_P1_MODE_SELF     8'h15
`define SPP_OFS_P2_MIRROR_VLAN   8'h21
`define SPP_OFS_P2_FILTER_FLOW   8'h22
`define SPP_OFS_P2_TAG_HIGH      8'h23
`define SPP_OFS_P2_TAG_LOW       8'h24
`define SPP_OFS_P2_MODE_SELF     8'h25
`define SPP_OFS_P3_MIRROR_VLAN   8'h31
`define SPP_OFS_P3_FILTER_FLOW   8'h32
`define SPP_OFS_P3_TAG_HIGH      8'h33
`define SPP_OFS_P3_TAG_LOW       8'h34
`define SPP_OFS_P3_MODE_SELF     8'h35

// mirror / vlan control fields
`define SPP_BIT_MIRROR_DEST      7
`define SPP_BIT_RX_MIRROR        6
`define SPP_BIT_TX_MIRROR        5
`define SPP_BIT_DOUBLE_TAG       4
`define SPP_BIT_PRIO_CEILING     3
`define SPP_RST_MIRROR_VLAN      8'h07

// filter / flow control fields
`define SPP_BIT_SPLIT2           7
`define SPP_BIT_INGRESS_FILTER   6
`define SPP_BIT_DISCARD_NONPVID  5
`define SPP_BIT_FORCE_FC         4
`define SPP_BIT_BACK_PRESSURE    3
`define SPP_BIT_TX_ENABLE        2
`define SPP_BIT_RX_ENABLE        1
`define SPP_BIT_LEARN_DISABLE    0
`define SPP_RST_FILTER_FLOW      8'h06

// default tag
`define SPP_RST_TAG_HIGH         8'h00
`define SPP_RST_TAG_LOW          8'h01

// mode / self address fields
`define SPP_BIT_MII_MAC_MODE     7
`define SPP_BIT_SELF_FILTER      6
`define SPP_RST_MODE_SELF        8'h00

// strap capture delay in clock-enabled cycles
`define SPP_STRAP_WAIT           2'd2

`endif

// *** hw/spp_port_policy_regs.v ***
// per-port policy register bank of a three-port switch, with decoded
// policy outputs for the forwarding datapath
// assumes a synchronous byte-wide register access port on MCLK
//
// Contract
// (R1) mirror-destination bit makes port transmit monitored packets
// (R2) receive-mirror bit marks received packets monitored and copies to mirror port
// (R3) transmit-mirror bit marks transmitted packets monitored and copies them
// (R4) double-tag bit adds ingress default tag to every packet
// (R5) priority ceiling clamps packet priority to default-tag priority
// (R6) three-bit egress membership mask per port, resets to all ones
// (R7) software never sets two-queue and four-queue split together
// (R8) ingress filtering drops packets whose vlan membership lacks ingress port
// (R9) discard bit drops packets whose vlan id differs from default id
// (R10) force flow control overrides negotiation; ports 1,2 reset from straps; code ignores port 3 bit; any mapped register write before capture skips straps
// (R11) back-pressure bit enables half-duplex back pressure, resets zero
// (R12) transmit-enable bit gates transmission, resets one
// (R13) receive-enable bit gates reception, resets one
// (R14) learning-disable bit stops address learning, resets zero
// (R15) tag high byte: priority 7-5, cfi 4, vid 11-8, resets zero
// (R16) tag low byte holds vid 7-0, resets so vid is one
// (R17) default tag tags untagged ingress; default id used for lookup
// (R18) port 3 interface mode bit: one mac, zero phy; reserved port 2
// (R19) software sets port 1 mode bit to one for normal operation
// (R20) self-address filtering enable for port 1, absent on port 3
// (R21) four-queue split bit; clear means single queue; code also needs SPLIT2 clear
// (R22) inserted egress tag carries ingress default vlan id
// (R23) all fields read/write, take effect on next packet
`timescale 1ns/1ps
`include "spp_regs_map.vh"

module spp_port_policy_regs (
  input  wire        MCLK,
  input  wire        RESET_N,
  input  wire        CLK_EN,
  input  wire [7:0]  REG_ADDR,
  input  wire        REG_WR,
  input  wire        REG_RD,
  input  wire [7:0]  REG_WDATA,
  output reg  [7:0]  REG_RDATA,
  output reg         REG_RVALID,
  input  wire        FC_STRAP_A,
  input  wire        FC_STRAP_B,
  input  wire [2:0]  SPLIT4_EN,
  input  wire [2:0]  AN_FLOW_CTRL,
  input  wire [2:0]  PKT_VALID,
  input  wire [5:0]  PKT_IN_PORT,
  input  wire [8:0]  PKT_USER_PRIO,
  input  wire [2:0]  PKT_TAGGED,
  input  wire [35:0] PKT_VID,
  input  wire [8:0]  PKT_VLAN_MEMBERS,
  output reg  [2:0]  MIRROR_DEST,
  output reg  [2:0]  RX_MIRROR,
  output reg  [2:0]  TX_MIRROR,
  output reg  [8:0]  EGRESS_MEMBERS,
  output reg  [2:0]  SPLIT2,
  output reg  [2:0]  SINGLE_QUEUE,
  output reg  [2:0]  FLOW_CTRL_EN,
  output reg  [2:0]  BACK_PRESSURE,
  output reg  [2:0]  TX_ENABLE,
  output reg  [2:0]  RX_ENABLE,
  output reg  [2:0]  LEARN_DISABLE,
  output reg  [47:0] DEFAULT_TAG,
  output reg         PORT3_MAC_MODE,
  output reg  [1:0]  SELF_FILTER_EN,
  output reg  [2:0]  PKT_MONITORED,
  output reg  [2:0]  PKT_DROP,
  output reg  [2:0]  PKT_ADD_TAG,
  output reg  [8:0]  PKT_OUT_PRIO,
  output reg  [35:0] PKT_LOOKUP_VID
);

  // ----------------------------------------
  // register storage
  // ----------------------------------------
  reg [7:0] mirror_vlan [0:2];
  reg [7:0] filter_flow [0:2];
  reg [7:0] tag_high    [0:2];
  reg [7:0] tag_low     [0:2];
  reg [7:0] mode_self   [0:2];
  reg       strap_a_meta;
  reg       strap_a_sync;
  reg       strap_b_meta;
  reg       strap_b_sync;
  reg       strap_pending;
  reg [1:0] strap_wait;
  integer   i;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  // returns port index 0..2, or 3 when the page is unmapped
  function [1:0] port_of;
    input [7:0] addr;
    begin
      case (addr[7:4])
        4'h1:    port_of = 2'd0;
        4'h2:    port_of = 2'd1;
        4'h3:    port_of = 2'd2;
        default: port_of = 2'd3;
      endcase
    end
  endfunction

  wire [1:0] sel_port = port_of(REG_ADDR);
  wire [3:0] sel_reg  = REG_ADDR[3:0];
  wire       sel_ok   = (sel_port != 2'd3) && (sel_reg >= 4'h1) && (sel_reg <= 4'h5);

  // ----------------------------------------
  // per-port field helpers
  // ----------------------------------------
  // ingress port index, code 3 folds onto port 1
  function [1:0] ingress_index;
    input [1:0] code;
    begin
      if (code > 2'd2)
        ingress_index = 2'd0;
      else
        ingress_index = code;
    end
  endfunction

  // default vlan id of a port
  function [11:0] default_vid;
    input [1:0] port;
    begin
      default_vid = {tag_high[port][3:0], tag_low[port]};
    end
  endfunction

  // default user priority of a port
  function [2:0] default_prio;
    input [1:0] port;
    begin
      default_prio = tag_high[port][7:5];
    end
  endfunction

  // default tag of a port as one word
  function [15:0] port_tag;
    input [1:0] port;
    begin
      port_tag = {tag_high[port], tag_low[port]};
    end
  endfunction

  // force flow control of a port, no effect on port 3
  function flow_forced;
    input [1:0] port;
    begin
      if (port == 2'd2)
        flow_forced = 1'b0;
      else
        flow_forced = filter_flow[port][`SPP_BIT_FORCE_FC];
    end
  endfunction

  // register byte selected by port and register index
  function [7:0] read_byte;
    input [1:0] port;
    input [3:0] index;
    begin
      case (index)
        4'h1:    read_byte = mirror_vlan[port];
        4'h2:    read_byte = filter_flow[port];
        4'h3:    read_byte = tag_high[port];
        4'h4:    read_byte = tag_low[port];
        4'h5:    read_byte = mode_self[port];
        default: read_byte = 8'h00;
      endcase
    end
  endfunction

  // ----------------------------------------
  // strap synchronisers
  // ----------------------------------------
  always @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      strap_a_meta <= 1'b0;
      strap_a_sync <= 1'b0;
      strap_b_meta <= 1'b0;
      strap_b_sync <= 1'b0;
    end else if (CLK_EN) begin
      strap_a_meta <= FC_STRAP_A;
      strap_a_sync <= strap_a_meta;
      strap_b_meta <= FC_STRAP_B;
      strap_b_sync <= strap_b_meta;
    end
  end

  // (R10) capture waits for the synchronisers
  always @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      strap_wait <= `SPP_STRAP_WAIT;
    end else if (CLK_EN && strap_wait != 2'd0) begin
      strap_wait <= strap_wait - 2'd1;
    end
  end

  wire strap_ready = (strap_wait == 2'd0);

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  always @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      strap_pending <= 1'b1;
      for (i = 0; i < 3; i = i + 1) begin
        // (R6) membership all ones
        mirror_vlan[i] <= `SPP_RST_MIRROR_VLAN;
        // (R12) (R13) enables reset high
        filter_flow[i] <= `SPP_RST_FILTER_FLOW;
        // (R15) (R16) default tag reset
        tag_high[i]    <= `SPP_RST_TAG_HIGH;
        tag_low[i]     <= `SPP_RST_TAG_LOW;
        mode_self[i]   <= `SPP_RST_MODE_SELF;
      end
    end else if (CLK_EN) begin
      if (strap_pending && strap_ready && !(REG_WR && sel_ok)) begin
        // (R10) strap caught once synchronised if no write to a mapped register has come by then
        strap_pending <= 1'b0;
        filter_flow[0][`SPP_BIT_FORCE_FC] <= strap_a_sync;
        filter_flow[1][`SPP_BIT_FORCE_FC] <= strap_b_sync;
      end else if (REG_WR && sel_ok) begin
        strap_pending <= 1'b0;
        // (R23) software write
        case (sel_reg)
          4'h1:    mirror_vlan[sel_port] <= REG_WDATA;
          4'h2:    filter_flow[sel_port] <= REG_WDATA;
          4'h3:    tag_high[sel_port]    <= REG_WDATA;
          4'h4:    tag_low[sel_port]     <= REG_WDATA;
          // (R18) (R20) reserved bits stay zero
          4'h5: begin
            if (sel_port == 2'd0)
              mode_self[0] <= {REG_WDATA[7:6], 6'h00};
            else if (sel_port == 2'd1)
              mode_self[1] <= {1'b0, REG_WDATA[6], 6'h00};
            else
              mode_self[2] <= {REG_WDATA[7], 7'h00};
          end
          default: mode_self[0] <= mode_self[0];
        endcase
      end
    end
  end

  // ----------------------------------------
  // register reads
  // ----------------------------------------
  always @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      REG_RDATA  <= 8'h00;
      REG_RVALID <= 1'b0;
    end else if (CLK_EN) begin
      REG_RVALID <= REG_RD;
      // (R23) software read back
      if (REG_RD) begin
        REG_RDATA <= sel_ok ? read_byte(sel_port, sel_reg) : 8'h00;
      end
    end
  end

  // ----------------------------------------
  // policy decode per packet
  // ----------------------------------------
  reg  [2:0]  next_monitored;
  reg  [2:0]  next_drop;
  reg  [2:0]  next_add_tag;
  reg  [8:0]  next_prio;
  reg  [35:0] next_vid;
  reg  [1:0]  ip;
  reg  [2:0]  dprio;
  reg  [11:0] dvid;
  integer     k;

  always @* begin
    next_monitored = 3'b000;
    next_drop      = 3'b000;
    next_add_tag   = 3'b000;
    next_prio      = PKT_USER_PRIO;
    next_vid       = PKT_VID;
    ip             = 2'd0;
    dprio          = 3'd0;
    dvid           = 12'd0;
    for (k = 0; k < 3; k = k + 1) begin
      ip    = ingress_index(PKT_IN_PORT[2*k +: 2]);
      dprio = default_prio(ip);
      dvid  = default_vid(ip);
      if (PKT_VALID[k]) begin
        // (R2) (R3) monitored marking
        next_monitored[k] = mirror_vlan[ip][`SPP_BIT_RX_MIRROR] |
                            mirror_vlan[k][`SPP_BIT_TX_MIRROR];
        // (R8) ingress vlan filter
        if (filter_flow[ip][`SPP_BIT_INGRESS_FILTER] && !PKT_VLAN_MEMBERS[3*k + ip])
          next_drop[k] = 1'b1;
        // (R9) non-default vid discard
        if (filter_flow[ip][`SPP_BIT_DISCARD_NONPVID] && PKT_VID[12*k +: 12] != dvid)
          next_drop[k] = 1'b1;
        // (R13) (R12) reception and transmission gates
        if (!filter_flow[ip][`SPP_BIT_RX_ENABLE] || !filter_flow[k][`SPP_BIT_TX_ENABLE])
          next_drop[k] = 1'b1;
        // (R4) (R22) tag insertion request
        next_add_tag[k] = mirror_vlan[ip][`SPP_BIT_DOUBLE_TAG] | !PKT_TAGGED[k];
        // (R5) priority ceiling
        if (mirror_vlan[ip][`SPP_BIT_PRIO_CEILING] && PKT_USER_PRIO[3*k +: 3] > dprio)
          next_prio[3*k +: 3] = dprio;
        // (R17) default vid for lookup
        if (!PKT_TAGGED[k] || PKT_VID[12*k +: 12] == 12'h000)
          next_vid[12*k +: 12] = dvid;
      end
    end
  end

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  integer p;
  always @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      MIRROR_DEST    <= 3'b000;
      RX_MIRROR      <= 3'b000;
      TX_MIRROR      <= 3'b000;
      EGRESS_MEMBERS <= 9'h1FF;
      SPLIT2         <= 3'b000;
      SINGLE_QUEUE   <= 3'b111;
      FLOW_CTRL_EN   <= 3'b000;
      BACK_PRESSURE  <= 3'b000;
      TX_ENABLE      <= 3'b111;
      RX_ENABLE      <= 3'b111;
      LEARN_DISABLE  <= 3'b000;
      DEFAULT_TAG    <= 48'h000100010001;
      PORT3_MAC_MODE <= 1'b0;
      SELF_FILTER_EN <= 2'b00;
      PKT_MONITORED  <= 3'b000;
      PKT_DROP       <= 3'b000;
      PKT_ADD_TAG    <= 3'b000;
      PKT_OUT_PRIO   <= 9'h000;
      PKT_LOOKUP_VID <= 36'h000000000;
    end else if (CLK_EN) begin
      for (p = 0; p < 3; p = p + 1) begin
        // (R1) mirror destination
        MIRROR_DEST[p]        <= mirror_vlan[p][`SPP_BIT_MIRROR_DEST];
        RX_MIRROR[p]          <= mirror_vlan[p][`SPP_BIT_RX_MIRROR];
        TX_MIRROR[p]          <= mirror_vlan[p][`SPP_BIT_TX_MIRROR];
        // (R6) egress membership
        EGRESS_MEMBERS[3*p +: 3] <= mirror_vlan[p][2:0];
        SPLIT2[p]             <= filter_flow[p][`SPP_BIT_SPLIT2];
        // (R21) (R7) single queue when no split
        SINGLE_QUEUE[p]       <= !filter_flow[p][`SPP_BIT_SPLIT2] && !SPLIT4_EN[p];
        // (R11) back pressure
        BACK_PRESSURE[p]      <= filter_flow[p][`SPP_BIT_BACK_PRESSURE];
        TX_ENABLE[p]          <= filter_flow[p][`SPP_BIT_TX_ENABLE];
        RX_ENABLE[p]          <= filter_flow[p][`SPP_BIT_RX_ENABLE];
        // (R14) learning gate
        LEARN_DISABLE[p]      <= filter_flow[p][`SPP_BIT_LEARN_DISABLE];
        DEFAULT_TAG[16*p +: 16] <= port_tag(p[1:0]);
      end
      // (R10) forced or negotiated flow control; port 3 bit ignored
      FLOW_CTRL_EN[0] <= flow_forced(2'd0) | AN_FLOW_CTRL[0];
      FLOW_CTRL_EN[1] <= flow_forced(2'd1) | AN_FLOW_CTRL[1];
      FLOW_CTRL_EN[2] <= flow_forced(2'd2) | AN_FLOW_CTRL[2];
      // (R18) port 3 interface mode
      PORT3_MAC_MODE  <= mode_self[2][`SPP_BIT_MII_MAC_MODE];
      // (R20) self-address filtering
      SELF_FILTER_EN  <= {mode_self[1][`SPP_BIT_SELF_FILTER],
                          mode_self[0][`SPP_BIT_SELF_FILTER]};
      PKT_MONITORED   <= next_monitored;
      PKT_DROP        <= next_drop;
      PKT_ADD_TAG     <= next_add_tag;
      PKT_OUT_PRIO    <= next_prio;
      PKT_LOOKUP_VID  <= next_vid;
    end
  end

endmodule

// *** bench/spp_port_policy_regs_chk.sv ***
// checker of the port policy bank, bound to its top module
// assumes one clock domain and an active-low asynchronous reset
`timescale 1ns/1ps
module spp_regs_chk (
  input logic        MCLK,
  input logic        RESET_N,
  input logic        CLK_EN,
  input logic [7:0]  REG_ADDR,
  input logic        REG_WR,
  input logic        REG_RD,
  input logic [7:0]  REG_WDATA,
  input logic [7:0]  REG_RDATA,
  input logic        REG_RVALID,
  input logic [2:0]  SPLIT4_EN,
  input logic [2:0]  AN_FLOW_CTRL,
  input logic [2:0]  PKT_VALID,
  input logic [5:0]  PKT_IN_PORT,
  input logic [2:0]  RX_MIRROR,
  input logic [2:0]  SINGLE_QUEUE,
  input logic [2:0]  FLOW_CTRL_EN,
  input logic [2:0]  TX_ENABLE,
  input logic [2:0]  RX_ENABLE,
  input logic [2:0]  PKT_MONITORED,
  input logic [2:0]  PKT_DROP
);
  // ------------------------------
  // properties
  // ------------------------------
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESET_N);
  sequence s_tag_wr;
    CLK_EN && REG_WR && REG_ADDR == 8'h13;
  endsequence
  sequence s_tag_rd;
    CLK_EN && REG_RD && !REG_WR && REG_ADDR == 8'h13;
  endsequence
  sequence s_lane1_from_p1;
    CLK_EN && PKT_VALID[1] && PKT_IN_PORT[3:2] == 2'd0;
  endsequence
  a_read_answer: assert property (CLK_EN && REG_RD |=> REG_RVALID)
    else $error("read not answered");
  a_tag_readback: assert property (s_tag_wr ##1 s_tag_rd |=> REG_RDATA == $past(REG_WDATA, 2))
    else $error("tag byte readback differs");
  a_unmapped_zero: assert property (CLK_EN && REG_RD && (REG_ADDR[3:0] == 4'h0
    || REG_ADDR[3:0] > 4'h5 || REG_ADDR[7:4] == 4'h0 || REG_ADDR[7:4] > 4'h3)
    |=> REG_RDATA == 8'h00) else $error("unmapped read not zero");
  a_tx_follow: assert property (CLK_EN && REG_WR && REG_ADDR == 8'h12
    |=> ##1 TX_ENABLE[0] == $past(REG_WDATA[2], 2)) else $error("tx enable lags");
  a_port3_fc: assert property (!AN_FLOW_CTRL[2] [*3] |-> !FLOW_CTRL_EN[2])
    else $error("port 3 forced flow control");
  a_split4_queue: assert property (SPLIT4_EN[1] [*3] |-> !SINGLE_QUEUE[1])
    else $error("single queue with split");
  a_rx_gate_drop: assert property (s_lane1_from_p1 ##1 !RX_ENABLE[0] |-> PKT_DROP[1])
    else $error("packet passed disabled rx");
  a_rx_mirror_mark: assert property (s_lane1_from_p1 ##1 RX_MIRROR[0] |-> PKT_MONITORED[1])
    else $error("packet not monitored");
endmodule
bind spp_port_policy_regs spp_regs_chk chk_u (.*);

// *** bench/tb_spp_port_policy_regs.sv ***
// self-checking bench of the port policy bank: registers and packet lane 1
// assumes the checker file binds itself to the design
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module tb_spp_port_policy_regs;
  logic        MCLK = 1'b0;
  logic        RESET_N = 1'b0;
  logic        CLK_EN = 1'b1;
  logic        FC_STRAP_A = 1'b1;
  logic        FC_STRAP_B = 1'b0;
  logic        REG_WR = 1'b0;
  logic        REG_RD = 1'b0;
  logic [7:0]  REG_ADDR = 8'h00;
  logic [7:0]  REG_WDATA = 8'h00;
  logic [2:0]  SPLIT4_EN = 3'h0;
  logic [2:0]  AN_FLOW_CTRL = 3'h0;
  logic [2:0]  PKT_VALID = 3'h0;
  logic [2:0]  PKT_TAGGED = 3'h0;
  logic [5:0]  PKT_IN_PORT = 6'h00;
  logic [8:0]  PKT_USER_PRIO = 9'h000;
  logic [8:0]  PKT_VLAN_MEMBERS = 9'h000;
  logic [35:0] PKT_VID = 36'h0;
  wire  [7:0]  REG_RDATA;
  wire         REG_RVALID, PORT3_MAC_MODE;
  wire  [2:0]  MIRROR_DEST, RX_MIRROR, TX_MIRROR, SPLIT2, SINGLE_QUEUE, FLOW_CTRL_EN;
  wire  [2:0]  BACK_PRESSURE, TX_ENABLE, RX_ENABLE, LEARN_DISABLE;
  wire  [2:0]  PKT_MONITORED, PKT_DROP, PKT_ADD_TAG;
  wire  [8:0]  EGRESS_MEMBERS, PKT_OUT_PRIO;
  wire  [1:0]  SELF_FILTER_EN;
  wire  [35:0] PKT_LOOKUP_VID;
  wire  [47:0] DEFAULT_TAG;
  int          n_fail = 0;
  int          num_checks = 0;

  spp_port_policy_regs dut_u (.*);

  always #4 MCLK = ~MCLK;

  // ------------------------------
  // access tasks
  // ------------------------------
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    REG_WR <= 1'b0;
    REG_RD <= 1'b1;
    REG_ADDR <= a;
    @(posedge MCLK);
    REG_RD <= 1'b0;
    @(negedge MCLK);
    `CHK(REG_RVALID, 1'b1)
    `CHK(REG_RDATA, e)
    @(posedge MCLK);
  endtask

  task automatic wrc(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
    REG_WR <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge MCLK);
    rd(a, e);
  endtask

  // x = {drop, monitored, add tag, priority, lookup vid}
  task automatic pkt(input logic t, input logic [2:0] pr, input logic [11:0] v,
                     input logic [2:0] m, input logic [17:0] x);
    PKT_VALID <= 3'h2;
    PKT_TAGGED <= {1'b0, t, 1'b0};
    PKT_USER_PRIO <= {3'h0, pr, 3'h0};
    PKT_VID <= {12'h000, v, 12'h000};
    PKT_VLAN_MEMBERS <= {3'h0, m, 3'h0};
    @(posedge MCLK);
    PKT_VALID <= 3'h0;
    @(negedge MCLK);
    `CHK(PKT_DROP[1], x[17])
    if (!x[17]) begin
      `CHK({PKT_MONITORED[1], PKT_ADD_TAG[1], PKT_OUT_PRIO[5:3], PKT_LOOKUP_VID[23:12]}, x[16:0])
    end
    @(posedge MCLK);
  endtask

  task automatic print_verdict();
    if (n_fail == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ------------------------------
  // sequence
  // ------------------------------
  initial begin
    repeat (3) @(posedge MCLK);
    RESET_N <= 1'b1;
    repeat (3) @(posedge MCLK);
    for (int p = 1; p < 4; p++) begin
      rd({p[3:0], 4'h1}, 8'h07);
      rd({p[3:0], 4'h2}, (p == 1) ? 8'h16 : 8'h06);
      rd({p[3:0], 4'h3}, 8'h00);
      rd({p[3:0], 4'h4}, 8'h01);
      rd({p[3:0], 4'h5}, 8'h00);
    end
    @(negedge MCLK);
    `CHK({EGRESS_MEMBERS, TX_ENABLE, RX_ENABLE, SINGLE_QUEUE}, 18'h3FFFF)
    `CHK({SPLIT2, LEARN_DISABLE, BACK_PRESSURE, FLOW_CTRL_EN}, 12'h001)
    `CHK(DEFAULT_TAG, 48'h000100010001)
    @(posedge MCLK);
    for (int p = 1; p < 4; p++)
      for (int r = 1; r < 6; r++)
        wrc({p[3:0], r[3:0]}, 8'hFF, (r < 5) ? 8'hFF : (p == 1) ? 8'hC0 :
            (p == 2) ? 8'h40 : 8'h80);
    @(negedge MCLK);
    `CHK(DEFAULT_TAG, 48'hFFFFFFFFFFFF)
    `CHK({PORT3_MAC_MODE, SELF_FILTER_EN}, 3'h7)
    `CHK({SPLIT2, LEARN_DISABLE, BACK_PRESSURE, SINGLE_QUEUE, FLOW_CTRL_EN}, 15'h7FC3)
    @(posedge MCLK);
    wrc(8'h15, 8'h80, 8'h80);
    wrc(8'h16, 8'h5A, 8'h00);
    rd(8'h10, 8'h00);
    rd(8'h40, 8'h00);
    wrc(8'h11, 8'h4F, 8'h4F);
    wrc(8'h12, 8'h46, 8'h46);
    wrc(8'h13, 8'h40, 8'h40);
    wrc(8'h14, 8'h05, 8'h05);
    wrc(8'h21, 8'h05, 8'h05);
    wrc(8'h22, 8'h06, 8'h06);
    @(negedge MCLK);
    `CHK({MIRROR_DEST, RX_MIRROR, TX_MIRROR}, 9'b100101100)
    `CHK({EGRESS_MEMBERS, SINGLE_QUEUE}, 12'hF7B)
    @(posedge MCLK);
    SPLIT4_EN <= 3'h2;
    AN_FLOW_CTRL <= 3'h4;
    repeat (3) @(posedge MCLK);
    @(negedge MCLK);
    `CHK({SINGLE_QUEUE, FLOW_CTRL_EN}, 6'b001100)
    @(posedge MCLK);
    SPLIT4_EN <= 3'h0;
    AN_FLOW_CTRL <= 3'h0;
    pkt(1'b1, 3'd6, 12'h005, 3'h1, {3'b010, 3'd2, 12'h005});
    pkt(1'b1, 3'd1, 12'h005, 3'h1, {3'b010, 3'd1, 12'h005});
    pkt(1'b1, 3'd6, 12'h005, 3'h2, 18'h20000);
    pkt(1'b0, 3'd2, 12'h000, 3'h1, {3'b011, 3'd2, 12'h005});
    wrc(8'h11, 8'h5F, 8'h5F);
    pkt(1'b1, 3'd1, 12'h005, 3'h1, {3'b011, 3'd1, 12'h005});
    wrc(8'h12, 8'h26, 8'h26);
    pkt(1'b1, 3'd1, 12'h006, 3'h1, 18'h20000);
    pkt(1'b1, 3'd1, 12'h005, 3'h2, {3'b011, 3'd1, 12'h005});
    wrc(8'h12, 8'h04, 8'h04);
    pkt(1'b1, 3'd1, 12'h005, 3'h1, 18'h20000);
    wrc(8'h12, 8'h06, 8'h06);
    wrc(8'h22, 8'h02, 8'h02);
    pkt(1'b1, 3'd1, 12'h005, 3'h1, 18'h20000);
    wrc(8'h22, 8'h06, 8'h06);
    wrc(8'h11, 8'h1F, 8'h1F);
    pkt(1'b1, 3'd1, 12'h005, 3'h1, {3'b001, 3'd1, 12'h005});
    wrc(8'h21, 8'h25, 8'h25);
    pkt(1'b1, 3'd1, 12'h005, 3'h1, {3'b011, 3'd1, 12'h005});
    CLK_EN <= 1'b0;
    REG_WR <= 1'b1;
    REG_ADDR <= 8'h13;
    REG_WDATA <= 8'h77;
    @(posedge MCLK);
    CLK_EN <= 1'b1;
    rd(8'h13, 8'h40);
    print_verdict();
  end
endmodule
